// ---- hdl/itm_pkg.sv ----
package itm_pkg;

	// ==========================================================
	// Sizes
	localparam int MAX_INPUTS = 8;
	localparam int SRC_W = 3;
	localparam int REG_ADDR_W = 6;
	localparam int MSG_ADDR_W = 12;

	// ==========================================================
	// Register map: address = {input index, slot}
	localparam logic [2:0] SLOT_PRI_ADDR = 3'h0;
	localparam logic [2:0] SLOT_PRI_TYPE = 3'h1;
	localparam logic [2:0] SLOT_EDGE_SEL = 3'h2;
	localparam logic [2:0] SLOT_SEC_ADDR = 3'h3;
	localparam logic [2:0] SLOT_SEC_TYPE = 3'h4;
	localparam logic [2:0] SLOT_STATUS = 3'h5;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ==========================================================
	// Type value fields
	localparam int TYPE_INVERT_BIT = 7;
	localparam int TYPE_TOGGLE_BIT = 6;
	localparam int TYPE_SENSOR_BIT = 5;
	localparam int TYPE_FEEDBACK_BIT = 4;
	localparam int TYPE_EXT_MSB = 3;
	localparam logic [3:0] EXT_MAX = 4'h9;

	// ==========================================================
	// Edge select fields
	localparam int EDGE_PRI_RISE_BIT = 0;
	localparam int EDGE_PRI_FALL_BIT = 1;
	localparam int EDGE_SEC_RISE_BIT = 2;
	localparam int EDGE_SEC_FALL_BIT = 3;

	// ==========================================================
	// Status slot fields
	localparam int STAT_LEVEL_BIT = 0;
	localparam int STAT_TOGGLE_BIT = 1;
	localparam int STAT_PEND_PRI_BIT = 2;
	localparam int STAT_PEND_SEC_BIT = 3;

	// ==========================================================
	// Reset levels and limits
	localparam logic INPUT_IDLE_LEVEL = 1'b1;
	localparam logic TOGGLE_RESET = 1'b0;
	localparam logic [MSG_ADDR_W-1:0] MSG_ADDR_MAX = 12'h9ff;

	typedef enum logic [1:0] {
		KIND_SWITCH,
		KIND_FEEDBACK,
		KIND_SENSOR
	} itm_kind_type;

	typedef struct packed {
		logic [REG_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} itm_reg_req_type;

	typedef struct packed {
		itm_kind_type kind;
		logic [MSG_ADDR_W-1:0] addr;
		logic state;
		logic [SRC_W-1:0] src;
		logic secondary;
	} itm_msg_type;

endpackage

// ---- hdl/itm_messenger.sv ----
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module itm_messenger
	import itm_pkg::*;
#(
	parameter int NUM_INPUTS = MAX_INPUTS
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Input pins
	input wire logic [NUM_INPUTS-1:0] sense_in,
	// Register port
	input wire itm_reg_req_type reg_req_in,
	output logic [7:0] rd_data_out,
	// Message port towards the serial bus
	output logic msg_valid_out,
	output itm_msg_type msg_out,
	input wire logic msg_ready_in
);

	// ==========================================================
	// Parameter check
	if (NUM_INPUTS < 1 || NUM_INPUTS > MAX_INPUTS) begin : g_bad_inputs
		$error("NUM_INPUTS must lie between 1 and MAX_INPUTS");
	end

	// ==========================================================
	// Configuration storage
	logic [7:0] cfg_pri_addr [NUM_INPUTS];
	logic [7:0] cfg_pri_type [NUM_INPUTS];
	logic [7:0] cfg_edge_sel [NUM_INPUTS];
	logic [7:0] cfg_sec_addr [NUM_INPUTS];
	logic [7:0] cfg_sec_type [NUM_INPUTS];

	// ==========================================================
	// Input and message state
	logic [NUM_INPUTS-1:0] sync_a;
	logic [NUM_INPUTS-1:0] sync_b;
	logic [NUM_INPUTS-1:0] level;
	logic [NUM_INPUTS-1:0] rise;
	logic [NUM_INPUTS-1:0] fall;
	logic [NUM_INPUTS-1:0] fire_pri;
	logic [NUM_INPUTS-1:0] fire_sec;
	logic [NUM_INPUTS-1:0] pend_pri;
	logic [NUM_INPUTS-1:0] pend_sec;
	logic [NUM_INPUTS-1:0] pri_lvl;
	logic [NUM_INPUTS-1:0] sec_lvl;
	logic [NUM_INPUTS-1:0] tog;
	logic msg_valid;
	itm_msg_type msg;
	logic [7:0] rd_data;

	logic found;
	logic [SRC_W-1:0] sel_idx;
	logic sel_sec;
	logic [7:0] sel_type;
	logic [7:0] sel_base;
	logic sel_lvl;
	logic sel_tog_mode;
	logic [3:0] sel_ext;
	logic msg_load;
	itm_msg_type next_msg;

	logic [SRC_W-1:0] req_idx;
	logic [2:0] req_slot;
	logic req_hit;

	assign req_idx = reg_req_in.addr[REG_ADDR_W-1:3];
	assign req_slot = reg_req_in.addr[2:0];
	assign req_hit = (32'(req_idx) < NUM_INPUTS);

	// ==========================================================
	// Pin synchroniser; idle level avoids a false edge after reset
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_a <= {NUM_INPUTS{INPUT_IDLE_LEVEL}};
			sync_b <= {NUM_INPUTS{INPUT_IDLE_LEVEL}};
			level <= {NUM_INPUTS{INPUT_IDLE_LEVEL}};
		end else begin
			sync_a <= sense_in;
			sync_b <= sync_a;
			level <= sync_b;
		end
	end

	// ==========================================================
	// Edge detection and trigger selection
	assign rise = sync_b & ~level;
	assign fall = ~sync_b & level;

	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			fire_pri[i] = (rise[i] & cfg_edge_sel[i][EDGE_PRI_RISE_BIT]) |
				(fall[i] & cfg_edge_sel[i][EDGE_PRI_FALL_BIT]);
			fire_sec[i] = (rise[i] & cfg_edge_sel[i][EDGE_SEC_RISE_BIT]) |
				(fall[i] & cfg_edge_sel[i][EDGE_SEC_FALL_BIT]);
		end
	end

	// ==========================================================
	// Register writes, one value group per input
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				cfg_pri_addr[i] <= CFG_RESET;
				cfg_pri_type[i] <= CFG_RESET;
				cfg_edge_sel[i] <= CFG_RESET;
				cfg_sec_addr[i] <= CFG_RESET;
				cfg_sec_type[i] <= CFG_RESET;
			end
		end else if (reg_req_in.wr && req_hit) begin
			case (req_slot)
				SLOT_PRI_ADDR: cfg_pri_addr[req_idx] <= reg_req_in.wdata;
				SLOT_PRI_TYPE: cfg_pri_type[req_idx] <= reg_req_in.wdata;
				SLOT_EDGE_SEL: cfg_edge_sel[req_idx] <= reg_req_in.wdata;
				SLOT_SEC_ADDR: cfg_sec_addr[req_idx] <= reg_req_in.wdata;
				SLOT_SEC_TYPE: cfg_sec_type[req_idx] <= reg_req_in.wdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Register reads; data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data <= READ_ZERO;
		end else if (reg_req_in.rd && req_hit) begin
			case (req_slot)
				SLOT_PRI_ADDR: rd_data <= cfg_pri_addr[req_idx];
				SLOT_PRI_TYPE: rd_data <= cfg_pri_type[req_idx];
				SLOT_EDGE_SEL: rd_data <= cfg_edge_sel[req_idx];
				SLOT_SEC_ADDR: rd_data <= cfg_sec_addr[req_idx];
				SLOT_SEC_TYPE: rd_data <= cfg_sec_type[req_idx];
				SLOT_STATUS: begin
					rd_data <= READ_ZERO;
					rd_data[STAT_LEVEL_BIT] <= level[req_idx];
					rd_data[STAT_TOGGLE_BIT] <= tog[req_idx];
					rd_data[STAT_PEND_PRI_BIT] <= pend_pri[req_idx];
					rd_data[STAT_PEND_SEC_BIT] <= pend_sec[req_idx];
				end
				default: rd_data <= READ_ZERO;
			endcase
		end else begin
			rd_data <= READ_ZERO;
		end
	end

	// ==========================================================
	// Pick the lowest input with work; its primary always goes first
	always_comb begin
		found = 1'b0;
		sel_idx = '0;
		sel_sec = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (!found && (pend_pri[i] || pend_sec[i])) begin
				found = 1'b1;
				sel_idx = SRC_W'(i);
				sel_sec = !pend_pri[i];
			end
		end
	end

	// ==========================================================
	// Message assembly
	always_comb begin
		sel_type = sel_sec ? cfg_sec_type[sel_idx] : cfg_pri_type[sel_idx];
		sel_base = sel_sec ? cfg_sec_addr[sel_idx] : cfg_pri_addr[sel_idx];
		sel_lvl = sel_sec ? sec_lvl[sel_idx] : pri_lvl[sel_idx];
		// Toggle only counts for a primary switch command; secondary bit is ignored
		sel_tog_mode = !sel_sec && sel_type[TYPE_TOGGLE_BIT] &&
			!sel_type[TYPE_SENSOR_BIT] && !sel_type[TYPE_FEEDBACK_BIT];
		// Out-of-range selectors fall back to no extension
		sel_ext = (sel_type[TYPE_EXT_MSB:0] > EXT_MAX) ? 4'h0 : sel_type[TYPE_EXT_MSB:0];
		next_msg.addr = {4'h0, sel_base} + {sel_ext, 8'h00};
		if (sel_type[TYPE_SENSOR_BIT]) begin
			next_msg.kind = KIND_SENSOR;
		end else if (sel_type[TYPE_FEEDBACK_BIT]) begin
			next_msg.kind = KIND_FEEDBACK;
		end else begin
			next_msg.kind = KIND_SWITCH;
		end
		next_msg.state = (sel_tog_mode ? ~tog[sel_idx] : sel_lvl) ^
			sel_type[TYPE_INVERT_BIT];
		next_msg.src = sel_idx;
		next_msg.secondary = sel_sec;
	end

	assign msg_load = found && (!msg_valid || msg_ready_in);

	// ==========================================================
	// Pending messages; a new edge wins over the clear by a send
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_pri <= '0;
			pend_sec <= '0;
			pri_lvl <= '0;
			sec_lvl <= '0;
		end else begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				if (fire_pri[i]) begin
					pend_pri[i] <= 1'b1;
					pri_lvl[i] <= sync_b[i];
				end else if (msg_load && !sel_sec && 32'(sel_idx) == i) begin
					pend_pri[i] <= 1'b0;
				end
				if (fire_sec[i]) begin
					pend_sec[i] <= 1'b1;
					sec_lvl[i] <= sync_b[i];
				end else if (msg_load && sel_sec && 32'(sel_idx) == i) begin
					pend_sec[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Toggle memory, flips on each toggled primary sent
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tog <= {NUM_INPUTS{TOGGLE_RESET}};
		end else if (msg_load && sel_tog_mode) begin
			tog[sel_idx] <= ~tog[sel_idx];
		end
	end

	// ==========================================================
	// Output message register, held until the bus takes it
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			msg_valid <= 1'b0;
			msg <= '0;
		end else if (msg_load) begin
			msg_valid <= 1'b1;
			msg <= next_msg;
		end else if (msg_ready_in) begin
			msg_valid <= 1'b0;
		end
	end

	assign msg_valid_out = msg_valid;
	assign msg_out = msg;
	assign rd_data_out = rd_data;

	// ==========================================================
	// Checks
	for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_chk
		AST_PRI_ON_RISE: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			rise[g] && cfg_edge_sel[g][EDGE_PRI_RISE_BIT] |=> pend_pri[g])
			else $error("primary not queued on rising edge");
		AST_PRI_OFF: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			!pend_pri[g] && cfg_edge_sel[g][1:0] == 2'h0 |=> !pend_pri[g])
			else $error("primary queued while suppressed");
		AST_SEC_ON_FALL: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			fall[g] && cfg_edge_sel[g][EDGE_SEC_FALL_BIT] |=> pend_sec[g])
			else $error("secondary not queued on falling edge");
		AST_FALL_FROM_PIN: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			fall[g] |-> $past(sync_b[g]) && !sync_b[g])
			else $error("falling edge without high to low change");
		AST_PRI_ON_FALL: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			fall[g] && cfg_edge_sel[g][EDGE_PRI_FALL_BIT] |=> pend_pri[g])
			else $error("primary not queued on falling edge");
		AST_SEC_ON_RISE: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			rise[g] && cfg_edge_sel[g][EDGE_SEC_RISE_BIT] |=> pend_sec[g])
			else $error("secondary not queued on rising edge");
		AST_SEC_OFF: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			!pend_sec[g] && cfg_edge_sel[g][EDGE_SEC_FALL_BIT:EDGE_SEC_RISE_BIT] == 2'h0 |=>
				!pend_sec[g])
			else $error("secondary queued while suppressed");
		AST_RISE_FROM_PIN: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			rise[g] |-> !$past(sync_b[g]) && sync_b[g])
			else $error("rising edge without low to high change");
	end

	AST_PRI_FIRST: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && sel_sec |-> !pend_pri[sel_idx])
		else $error("secondary sent ahead of primary");
	AST_ADDR_RANGE: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_valid |-> msg.addr <= MSG_ADDR_MAX)
		else $error("message address beyond extension range");
	AST_SENSOR_KIND: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && sel_type[TYPE_SENSOR_BIT] |=> msg_valid && msg.kind == KIND_SENSOR)
		else $error("sensor type not sent as sensor");
	AST_INVERT: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && !sel_tog_mode && sel_type[TYPE_INVERT_BIT] |=>
			msg.state == !$past(sel_lvl))
		else $error("inverted state not applied");
	AST_TOGGLE_FLIP: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && sel_tog_mode |=> tog[$past(sel_idx)] != $past(tog[sel_idx]))
		else $error("toggle state did not flip");
	AST_HOLD: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_valid && !msg_ready_in |=> msg_valid && $stable(msg))
		else $error("message dropped before acceptance");
	AST_FEEDBACK_KIND: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && !sel_type[TYPE_SENSOR_BIT] && sel_type[TYPE_FEEDBACK_BIT] |=>
			msg.kind == KIND_FEEDBACK)
		else $error("feedback type not sent as feedback");
	AST_SWITCH_KIND: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && !sel_type[TYPE_SENSOR_BIT] && !sel_type[TYPE_FEEDBACK_BIT] |=>
			msg.kind == KIND_SWITCH)
		else $error("switch type not sent as switch command");
	AST_STATE_LEVEL: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && !sel_tog_mode && !sel_type[TYPE_INVERT_BIT] |=>
			msg.state == $past(sel_lvl))
		else $error("normal state does not follow the input");
	AST_EXT_ADD: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && sel_type[TYPE_EXT_MSB:0] <= EXT_MAX |=>
			msg.addr[7:0] == $past(sel_base) &&
			msg.addr[MSG_ADDR_W-1:8] == $past(sel_type[TYPE_EXT_MSB:0]))
		else $error("address extension not applied");
	AST_SEC_NO_TOGGLE: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		msg_load && sel_sec |=> $stable(tog))
		else $error("secondary message moved the toggle state");
	AST_RD_IDLE: assert property (
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		!reg_req_in.rd |=> rd_data == READ_ZERO)
		else $error("read data present without a read");

endmodule

// ---- bench/itm_bus_model.sv ----
`timescale 1ns/10ps
module itm_bus_model
	import itm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Message port
	input wire logic msg_valid_in,
	input wire itm_msg_type msg_in,
	output logic msg_ready_out,
	// Observation
	input wire logic slow_in,
	output logic got_out,
	output itm_msg_type got_msg_out,
	output logic [7:0] count_out
);
	logic [1:0] phase;

	// ==========================================================
	// Acceptance
	// A slow bus takes one slot in four, as a busy shared line would
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase <= 2'h0;
			msg_ready_out <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			msg_ready_out <= !slow_in || (phase == 2'h2);
		end
	end

	// Switch, feedback and sensor messages are all taken whole
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			got_out <= 1'b0;
			got_msg_out <= '0;
			count_out <= 8'h00;
		end else begin
			got_out <= msg_valid_in && msg_ready_out;
			if (msg_valid_in && msg_ready_out) begin
				got_msg_out <= msg_in;
				count_out <= count_out + 8'h01;
			end
		end
	end
endmodule

// ---- bench/input_transition_messenger_tb.sv ----
`timescale 1ns/10ps
module input_transition_messenger_tb
	import itm_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_b_in;
	logic [7:0] sense;
	itm_reg_req_type req;
	logic [7:0] rd_data;
	logic msg_valid;
	itm_msg_type msg;
	logic msg_ready;
	logic slow;
	logic got;
	itm_msg_type got_msg;
	logic [7:0] count;
	int n_mismatch = 0;
	int check_count = 0;

	// ==========================================================
	// Design and bus side
	itm_messenger #(.NUM_INPUTS(8)) dut (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .sense_in(sense),
		.reg_req_in(req), .rd_data_out(rd_data),
		.msg_valid_out(msg_valid), .msg_out(msg), .msg_ready_in(msg_ready)
	);
	itm_bus_model bus_model (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .msg_valid_in(msg_valid),
		.msg_in(msg), .msg_ready_out(msg_ready), .slow_in(slow),
		.got_out(got), .got_msg_out(got_msg), .count_out(count)
	);

	always #2 sys_clk_in = ~sys_clk_in;

	// ==========================================================
	// Helpers
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] mk(input itm_kind_type k, input logic [11:0] a,
			input logic s, input logic [2:0] i, input logic sec);
		itm_msg_type m;
		m = '{kind: k, addr: a, state: s, src: i, secondary: sec};
		return 32'(m);
	endfunction

	task automatic wr(input int i, input int s, input logic [7:0] d);
		@(posedge sys_clk_in);
		req <= '{addr: {3'(i), 3'(s)}, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_in);
		req.wr <= 1'b0;
	endtask

	task automatic rcheck(input int i, input int s, input logic [7:0] exp);
		@(posedge sys_clk_in);
		req <= '{addr: {3'(i), 3'(s)}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_in);
		req.rd <= 1'b0;
		#1;
		check(32'(rd_data), 32'(exp));
	endtask

	task automatic cfg(input int i, input logic [7:0] pa, input logic [7:0] pt,
			input logic [7:0] es, input logic [7:0] sa, input logic [7:0] st);
		wr(i, 0, pa);
		wr(i, 1, pt);
		wr(i, 2, es);
		wr(i, 3, sa);
		wr(i, 4, st);
	endtask

	task automatic pin(input int i, input logic v);
		@(posedge sys_clk_in);
		sense[i] <= v;
	endtask

	// Waits for the bus side to take one message, then compares it
	task automatic expect_msg(input logic [31:0] exp);
		int k;
		for (k = 0; k < 64; k++) begin
			@(posedge sys_clk_in);
			#1;
			if (got === 1'b1) break;
		end
		if (k == 64) begin
			n_mismatch++;
			test_done();
		end else begin
			check(32'(got_msg), exp);
		end
	endtask

	task automatic quiet(input logic [7:0] n);
		repeat (24) @(posedge sys_clk_in);
		#1;
		check(32'(count), 32'(n));
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_mismatch++;
		test_done();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst_b_in = 1'b0;
		sense = 8'hff;
		req = '0;
		slow = 1'b0;
		repeat (6) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 8; i++) for (int s = 0; s < 5; s++) rcheck(i, s, 8'h00);
		for (int i = 0; i < 8; i++) for (int s = 0; s < 5; s++) wr(i, s, {3'(i), 2'h1, 3'(s)});
		for (int i = 0; i < 8; i++) for (int s = 0; s < 5; s++) rcheck(i, s, {3'(i), 2'h1, 3'(s)});
		wr(0, 6, 8'hff);
		rcheck(0, 6, 8'h00);
		rcheck(2, 7, 8'h00);
		rcheck(0, 5, 8'h01);
		// Block detector with a falling-edge switch command, bus stalling
		cfg(0, 8'h01, 8'ha0, 8'h0b, 8'h3c, 8'h00);
		slow <= 1'b1;
		pin(0, 1'b0);
		expect_msg(mk(KIND_SENSOR, 12'd1, 1'b1, 3'd0, 1'b0));
		expect_msg(mk(KIND_SWITCH, 12'd60, 1'b0, 3'd0, 1'b1));
		slow <= 1'b0;
		pin(0, 1'b1);
		expect_msg(mk(KIND_SENSOR, 12'd1, 1'b0, 3'd0, 1'b0));
		quiet(8'd3);
		// Rising only, with address extension on both messages
		cfg(1, 8'd133, 8'h13, 8'h05, 8'h07, 8'h02);
		pin(1, 1'b0);
		quiet(8'd3);
		pin(1, 1'b1);
		expect_msg(mk(KIND_FEEDBACK, 12'd901, 1'b1, 3'd1, 1'b0));
		expect_msg(mk(KIND_SWITCH, 12'd519, 1'b1, 3'd1, 1'b1));
		// Toggled switch message on falling edges only
		cfg(2, 8'h05, 8'h40, 8'h02, 8'h00, 8'h00);
		pin(2, 1'b0);
		expect_msg(mk(KIND_SWITCH, 12'd5, 1'b1, 3'd2, 1'b0));
		rcheck(2, 5, 8'h02);
		pin(2, 1'b1);
		quiet(8'd6);
		pin(2, 1'b0);
		expect_msg(mk(KIND_SWITCH, 12'd5, 1'b0, 3'd2, 1'b0));
		// Secondary only, both edges, toggle bit set
		cfg(3, 8'h09, 8'h00, 8'h0c, 8'd200, 8'h60);
		pin(3, 1'b0);
		expect_msg(mk(KIND_SENSOR, 12'd200, 1'b0, 3'd3, 1'b1));
		pin(3, 1'b1);
		expect_msg(mk(KIND_SENSOR, 12'd200, 1'b1, 3'd3, 1'b1));
		quiet(8'd9);
		test_done();
	end
endmodule
